// ### include/csr_consts.svh
`ifndef CSR_CONSTS_SVH
`define CSR_CONSTS_SVH

// register byte addresses
`define CSR_ADDR_CTRL     8'h00
`define CSR_ADDR_TXDATA   8'h04
`define CSR_ADDR_RXDATA   8'h08
`define CSR_ADDR_STATUS   8'h0C
`define CSR_ADDR_IRQ_STAT 8'h10
`define CSR_ADDR_IRQ_CLR  8'h14
`define CSR_ADDR_IRQ_EN   8'h18

// control register fields
`define CSR_CTRL_RX_EN    0
`define CSR_CTRL_TX_EN    1
`define CSR_CTRL_MASTER   2
`define CSR_CTRL_CTS_EN   3
`define CSR_CTRL_RIE      4
`define CSR_CTRL_W        5
`define CSR_CTRL_RESET    5'h00

// serial status fields
`define CSR_ST_OVERRUN    0
`define CSR_ST_RX_FULL    1
`define CSR_ST_CLK_RUN    2
`define CSR_ST_TX_LOADED  3

// interrupt status / clear / enable fields
`define CSR_IRQ_DONE      0
`define CSR_IRQ_ERR       1
`define CSR_IRQ_W         2
`define CSR_IRQ_RESET     2'h0

// timing: shift clock half period in hclk cycles (10 MHz hclk, 800 ns link)
`define CSR_HCLK_NS       100
`define CSR_SCK_PERIOD_NS 800
`define CSR_SCK_HALF_CYC  ((`CSR_SCK_PERIOD_NS / 2) / `CSR_HCLK_NS)
`define CSR_BYTE_BITS     8

`endif

// ### include/csr_pkg.sv
package csr_pkg;
  typedef enum logic [1:0] {
    CSR_SCK_IDLE,
    CSR_SCK_LOW,
    CSR_SCK_HIGH
  } csr_sck_state_t;
endpackage

// ### rtl/csr_sck_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "csr_consts.svh"

// master shift clock: idles high, falls, then rises once per bit
module csr_sck_gen #(
  parameter int HALF_CYC = `CSR_SCK_HALF_CYC
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic run,
  output var  logic sck_ff,
  output var  logic rise_ff
);
  localparam int CW = $clog2(HALF_CYC + 1);

  csr_pkg::csr_sck_state_t state_ff;
  logic [CW-1:0]           cnt_ff;
  logic                    half_end;

  initial begin
    if (HALF_CYC < 3) begin
      $error("csr_sck_gen: HALF_CYC must be at least 3");
    end
  end

  assign half_end = (cnt_ff == CW'(HALF_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= csr_pkg::CSR_SCK_IDLE;
      cnt_ff   <= '0;
      sck_ff   <= 1'b1;
      rise_ff  <= 1'b0;
    end else begin
      rise_ff <= 1'b0;
      cnt_ff  <= half_end ? '0 : cnt_ff + 1'b1;
      case (state_ff)
        csr_pkg::CSR_SCK_IDLE: begin
          cnt_ff <= '0;
          if (run) begin
            state_ff <= csr_pkg::CSR_SCK_LOW;
            sck_ff   <= 1'b0;
          end
        end
        csr_pkg::CSR_SCK_LOW: begin
          if (half_end) begin
            state_ff <= csr_pkg::CSR_SCK_HIGH;
            sck_ff   <= 1'b1;
            rise_ff  <= 1'b1;
          end
        end
        csr_pkg::CSR_SCK_HIGH: begin
          if (half_end) begin
            state_ff <= run ? csr_pkg::CSR_SCK_LOW : csr_pkg::CSR_SCK_IDLE;
            sck_ff   <= ~run;
          end
        end
        default: begin
          state_ff <= csr_pkg::CSR_SCK_IDLE;
          sck_ff   <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### rtl/csr_shift.sv
`timescale 1ns/100ps
`default_nettype none
`include "csr_consts.svh"

// lsb-first deserialiser; bit count restarts whenever it is disabled
module csr_shift #(
  parameter int BITS = `CSR_BYTE_BITS
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            enable,
  input  wire logic            sample,
  input  wire logic            sdata,
  output var  logic            done_ff,
  output var  logic [BITS-1:0] data_ff
);
  localparam int CW = $clog2(BITS);

  logic [BITS-1:0] sh_ff;
  logic [CW-1:0]   cnt_ff;
  logic [BITS-1:0] nxt_sh;

  initial begin
    if (BITS < 2) begin
      $error("csr_shift: BITS must be at least 2");
    end
  end

  assign nxt_sh = {sdata, sh_ff[BITS-1:1]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_ff   <= '0;
      cnt_ff  <= '0;
      done_ff <= 1'b0;
      data_ff <= '0;
    end else begin
      done_ff <= 1'b0;
      if (!enable) begin
        cnt_ff <= '0;
      end else if (sample) begin
        sh_ff <= nxt_sh;
        if (cnt_ff == CW'(BITS - 1)) begin
          cnt_ff  <= '0;
          done_ff <= 1'b1;
          data_ff <= nxt_sh;
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/csr_top.sv
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "csr_consts.svh"

module csr_top #(
  parameter int HALF_CYC = `CSR_SCK_HALF_CYC,
  parameter int BITS     = `CSR_BYTE_BITS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        sck_in,
  output var  logic        sck_out,
  output var  logic        sck_oe,
  input  wire logic        sdata_in,
  input  wire logic        clear_to_send_input_n,
  output var  logic        irq
);
  initial begin
    if (BITS > 32) begin
      $error("csr_top: BITS must not exceed 32");
    end
  end

  // bus state
  logic [31:0]           hrdata_ff;
  logic                  hreadyout_ff;
  logic                  hresp_ff;
  logic                  wr_pend_ff;
  logic [7:0]            wr_addr_ff;
  logic                  rd_take;
  logic                  wr_take;
  // software state
  logic [`CSR_CTRL_W-1:0] ctrl_ff;
  logic [BITS-1:0]        rxbuf_ff;
  logic                   rx_full_ff;
  logic                   ovr_ff;
  logic                   burst_ff;
  logic                   tx_loaded_ff;
  logic [`CSR_IRQ_W-1:0]  irq_st_ff;
  logic [`CSR_IRQ_W-1:0]  irq_en_ff;
  logic                   irq_ff;
  logic                   sck_oe_ff;
  // pin synchronisers
  logic                   sck_meta_ff;
  logic                   sck_sync_ff;
  logic                   sck_prev_ff;
  logic                   sd_meta_ff;
  logic                   sd_sync_ff;
  logic                   cts_meta_ff;
  logic                   cts_sync_ff;
  // datapath
  logic                   rx_en;
  logic                   tx_en;
  logic                   master;
  logic                   rx_irq_request_enable;
  logic                   cont_run;
  logic                   run;
  logic                   gen_sck;
  logic                   gen_rise;
  logic                   ext_rise;
  logic                   sample;
  logic                   shift_en;
  logic                   byte_done;
  logic [BITS-1:0]        byte_data;
  logic                   ovr_evt;
  logic                   done_evt;
  logic                   wr_tx;
  logic                   wr_ssr;
  logic                   wr_irq_clr;
  logic                   rd_rx;

  assign rx_en  = ctrl_ff[`CSR_CTRL_RX_EN];
  assign tx_en  = ctrl_ff[`CSR_CTRL_TX_EN];
  assign master = ctrl_ff[`CSR_CTRL_MASTER];
  assign rx_irq_request_enable    = ctrl_ff[`CSR_CTRL_RIE];

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == `CSR_ADDR_CTRL) begin
      d[`CSR_CTRL_W-1:0] = ctrl_ff;
    end else if (a == `CSR_ADDR_RXDATA) begin
      d[BITS-1:0] = rxbuf_ff;
    end else if (a == `CSR_ADDR_STATUS) begin
      d[`CSR_ST_OVERRUN]   = ovr_ff;
      d[`CSR_ST_RX_FULL]   = rx_full_ff;
      d[`CSR_ST_CLK_RUN]   = run;
      d[`CSR_ST_TX_LOADED] = tx_loaded_ff;
    end else if (a == `CSR_ADDR_IRQ_STAT) begin
      d[`CSR_IRQ_W-1:0] = irq_st_ff;
    end else if (a == `CSR_ADDR_IRQ_EN) begin
      d[`CSR_IRQ_W-1:0] = irq_en_ff;
    end
    return d;
  endfunction

  // ahb-lite slave: zero wait states, always okay
  assign rd_take = hsel & hready & htrans[1] & ~hwrite;
  assign wr_take = hsel & hready & htrans[1] & hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= 8'h00;
    end else begin
      // never stalls, always okay
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      wr_pend_ff   <= wr_take;
      if (wr_take) begin
        wr_addr_ff <= haddr[7:0];
      end
      if (rd_take) begin
        hrdata_ff <= rd_mux(haddr[7:0]);
      end
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = hresp_ff;

  assign wr_tx      = wr_pend_ff & (wr_addr_ff == `CSR_ADDR_TXDATA);
  assign wr_ssr     = wr_pend_ff & (wr_addr_ff == `CSR_ADDR_STATUS);
  assign wr_irq_clr = wr_pend_ff & (wr_addr_ff == `CSR_ADDR_IRQ_CLR);
  assign rd_rx      = rd_take & (haddr[7:0] == `CSR_ADDR_RXDATA);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff   <= `CSR_CTRL_RESET;
      irq_en_ff <= `CSR_IRQ_RESET;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == `CSR_ADDR_CTRL) begin
        ctrl_ff <= hwdata[`CSR_CTRL_W-1:0];
      end else if (wr_addr_ff == `CSR_ADDR_IRQ_EN) begin
        irq_en_ff <= hwdata[`CSR_IRQ_W-1:0];
      end
    end
  end

  // pin inputs pass two flops before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_meta_ff <= 1'b1;
      sck_sync_ff <= 1'b1;
      sck_prev_ff <= 1'b1;
      sd_meta_ff  <= 1'b0;
      sd_sync_ff  <= 1'b0;
      cts_meta_ff <= 1'b1;
      cts_sync_ff <= 1'b1;
    end else begin
      sck_meta_ff <= sck_in;
      sck_sync_ff <= sck_meta_ff;
      sck_prev_ff <= sck_sync_ff;
      sd_meta_ff  <= sdata_in;
      sd_sync_ff  <= sd_meta_ff;
      cts_meta_ff <= clear_to_send_input_n;
      cts_sync_ff <= cts_meta_ff;
    end
  end

  assign cont_run = master & rx_en & ~tx_en & ~ovr_ff
                  & (~ctrl_ff[`CSR_CTRL_CTS_EN] | ~cts_sync_ff);
  assign run = cont_run | burst_ff;

  csr_sck_gen #(
    .HALF_CYC(HALF_CYC)
  ) u_sck_gen (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (run),
    .sck_ff  (gen_sck),
    .rise_ff (gen_rise)
  );

  // slave shifts on external rising edge
  assign ext_rise = sck_sync_ff & ~sck_prev_ff;
  assign sample   = master ? gen_rise : ext_rise;
  // slave with tx on waits for dummy data
  assign shift_en = rx_en & ~ovr_ff & (master | ~tx_en | tx_loaded_ff);

  csr_shift #(
    .BITS(BITS)
  ) u_shift (
    .hclk    (hclk),
    .hresetn (hresetn),
    .enable  (shift_en),
    .sample  (sample),
    .sdata   (sd_sync_ff),
    .done_ff (byte_done),
    .data_ff (byte_data)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_oe_ff <= 1'b0;
    end else begin
      sck_oe_ff <= master;
    end
  end

  assign sck_out = gen_sck;
  assign sck_oe  = sck_oe_ff;

  // dummy write starts exactly one byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      burst_ff <= 1'b0;
    end else if (byte_done | ~(master & rx_en & tx_en) | ovr_ff) begin
      burst_ff <= 1'b0;
    end else if (wr_tx) begin
      burst_ff <= 1'b1;
    end
  end

  // slave dummy data marks one byte ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_loaded_ff <= 1'b0;
    end else if (wr_tx & ~master & tx_en) begin
      tx_loaded_ff <= 1'b1;
    end else if (byte_done | ~tx_en | master) begin
      tx_loaded_ff <= 1'b0;
    end
  end

  // a byte completing over an unread one is an overrun
  assign ovr_evt  = byte_done & rx_full_ff;
  assign done_evt = byte_done & ~rx_full_ff;

  // completed byte goes into the receive buffer only when it is empty
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxbuf_ff   <= '0;
      rx_full_ff <= 1'b0;
    end else if (done_evt) begin
      rxbuf_ff   <= byte_data;
      rx_full_ff <= 1'b1;
    end else if (rd_rx) begin
      rx_full_ff <= 1'b0;
    end
  end

  // writing zero clears the overrun flag; a new overrun wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovr_ff <= 1'b0;
    end else if (ovr_evt) begin
      ovr_ff <= 1'b1;
    end else if (wr_ssr & ~hwdata[`CSR_ST_OVERRUN]) begin
      ovr_ff <= 1'b0;
    end
  end

  // events request interrupts only with request enable
  // overrun sets the error pending flag
  // error pending follows the error flags down
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_ff <= `CSR_IRQ_RESET;
    end else begin
      if (done_evt & rx_irq_request_enable) begin
        irq_st_ff[`CSR_IRQ_DONE] <= 1'b1;
      end else if (wr_irq_clr & hwdata[`CSR_IRQ_DONE]) begin
        irq_st_ff[`CSR_IRQ_DONE] <= 1'b0;
      end
      if (ovr_evt & rx_irq_request_enable) begin
        irq_st_ff[`CSR_IRQ_ERR] <= 1'b1;
      end else if (~ovr_ff | (wr_irq_clr & hwdata[`CSR_IRQ_ERR])) begin
        irq_st_ff[`CSR_IRQ_ERR] <= 1'b0;
      end
    end
  end

  // level interrupt from enabled pending flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_st_ff & irq_en_ff);
    end
  end

  assign irq = irq_ff;

endmodule
`default_nettype wire

// ### testbench/csr_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "csr_consts.svh"
module csr_checker #(
  parameter int HALF_CYC = 4
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        sck_out,
  input wire logic        sck_oe,
  input wire logic        clear_to_send_input_n,
  input wire logic        irq
);
  logic       dph_ff, dwr_ff, sq_ff;
  logic [7:0] dad_ff;
  logic [4:0] ctl_ff;
  logic [1:0] en_ff;
  logic [3:0] fc_ff;
  logic [5:0] nf_ff;
  wire logic  wr = dph_ff & dwr_ff & hready;
  wire logic  fall = sq_ff & ~sck_out;
  wire logic  burst = ctl_ff[2:0] == 3'h7;
  wire logic  cont = ctl_ff[2:0] == 3'h5;
  // shadow of the data phase and of the control and enable registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_ff <= 1'b0;
      dwr_ff <= 1'b0;
      dad_ff <= 8'h00;
      ctl_ff <= 5'h00;
      en_ff <= 2'h0;
    end else begin
      if (hready) begin
        dph_ff <= hsel & htrans[1];
        dwr_ff <= hwrite;
        dad_ff <= haddr[7:0];
      end
      if (wr && dad_ff == `CSR_ADDR_CTRL) ctl_ff <= hwdata[4:0];
      if (wr && dad_ff == `CSR_ADDR_IRQ_EN) en_ff <= hwdata[1:0];
    end
  end
  // falls per burst and cycles since the last fall in free-running mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sq_ff <= 1'b1;
      fc_ff <= 4'h0;
      nf_ff <= 6'h00;
    end else begin
      sq_ff <= sck_out;
      fc_ff <= (!burst || (wr && dad_ff == `CSR_ADDR_TXDATA)) ? 4'h0 : fc_ff + {3'h0, fall};
      nf_ff <= (fall || !cont || ctl_ff[3]) ? 6'h00 : nf_ff + {5'h0, nf_ff != 6'h3F};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus stall or error response");
  property p_burst_go; wr && dad_ff == `CSR_ADDR_TXDATA && burst |-> ##[1:3] !sck_out; endproperty
  a_burst_go: assert property (p_burst_go) else $error("burst clock did not start");
  property p_one_byte; burst |-> fc_ff <= 4'h8; endproperty
  a_one_byte: assert property (p_one_byte) else $error("burst gave more than a byte");
  property p_cont; nf_ff <= 2 * HALF_CYC + 4; endproperty
  a_cont: assert property (p_cont) else $error("free-running clock stalled");
  property p_cts; (cont && ctl_ff[3] && clear_to_send_input_n) [*8] |-> !fall; endproperty
  a_cts: assert property (p_cts) else $error("clock ran with send not cleared");
  property p_slave; !ctl_ff[2] [*2] |-> !sck_oe; endproperty
  a_slave: assert property (p_slave) else $error("slave drives the shift clock");
  property p_irq_en; irq |-> $past(en_ff) != 2'h0; endproperty
  a_irq_en: assert property (p_irq_en) else $error("interrupt with no enable");
  property p_err_clr;
    wr && dad_ff == `CSR_ADDR_STATUS && !hwdata[0] && en_ff == 2'h2 |-> ##[1:4] !irq;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("error interrupt not dropped");
endmodule
bind csr_top csr_checker #(.HALF_CYC(HALF_CYC)) chk_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .sck_out(sck_out),
  .sck_oe(sck_oe), .clear_to_send_input_n(clear_to_send_input_n), .irq(irq));
`default_nettype wire

// ### testbench/csr_far_end.sv
`timescale 1ns/100ps
`default_nettype none
module csr_far_end (
  input  wire logic sck_out,
  input  wire logic sck_oe,
  output var  logic sck_in,
  output var  logic sdata_in
);
  logic [7:0] mb = 8'h00;
  logic [3:0] idx = 4'h0;
  initial begin
    sck_in = 1'b1;
    sdata_in = 1'b0;
  end
  // external clock, lsb first, data set on the falling edge
  task automatic send(input logic [7:0] b);
    #37;
    for (int i = 0; i < 8; i++) begin
      sck_in = 1'b0;
      sdata_in = b[i];
      #400;
      sck_in = 1'b1;
      #400;
    end
    sdata_in = ~sdata_in;
  endtask
  task automatic arm(input logic [7:0] b);
    mb = b;
    idx = 4'h0;
  endtask
  always @(negedge sck_out) if (sck_oe) begin
    sdata_in = mb[idx[2:0]];
    idx = idx + 4'h1;
  end
  // released line shows the inverse once a byte is out
  always @(posedge sck_out) if (idx == 4'h8) begin
    sdata_in = ~sdata_in;
    idx = 4'h0;
  end
endmodule
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "csr_consts.svh"
module tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        cts_n = 1'b1;
  logic [31:0] hrdata, rd;
  logic        hready, hresp, sck_out, sck_oe, sck_ext, sdat, irq;
  logic [7:0]  b0, b1;
  int          errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          falls = 0;
  wire logic   sck_w = sck_oe ? sck_out : sck_ext;
  always #50 hclk = ~hclk;
  always @(negedge sck_out) falls++;
  csr_top #(.HALF_CYC(3)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .sck_in(sck_w), .sck_out(sck_out),
    .sck_oe(sck_oe), .sdata_in(sdat), .clear_to_send_input_n(cts_n), .irq(irq));
  csr_far_end far_u (.sck_out(sck_out), .sck_oe(sck_oe), .sck_in(sck_ext), .sdata_in(sdat));
  function automatic logic [31:0] exp_irq(input logic [1:0] st, input logic [1:0] en);
    return {31'h0, |(st & en)};
  endfunction
  function automatic logic [31:0] ctrlw(input logic rx, input logic tx, input logic ms,
                                        input logic cts);
    return {27'h0, 1'b1, cts, ms, tx, rx};
  endfunction
  task automatic final_report();
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask
  task automatic wirq();
    for (int n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge hclk);
    repeat (2) @(posedge hclk);
  endtask
  initial begin
    void'($urandom(32'h69A8));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    chk("pins", 32'h4, {29'h0, sck_out, sck_oe, irq});
    rchk("ctrl", `CSR_ADDR_CTRL, 32'h0);
    rchk("unmapped", 8'h1C, 32'h0);
    bus(1'b1, `CSR_ADDR_IRQ_EN, 32'h3);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, `CSR_ADDR_CTRL, ctrlw(1'b1, k[0], 1'b0, 1'b0));
      if (k == 1) begin
        bus(1'b1, `CSR_ADDR_TXDATA, $urandom);
        rchk("status", `CSR_ADDR_STATUS, 32'h8);
      end
      b0 = 8'($urandom);
      far_u.send(b0);
      wirq();
      chk("irq", 32'h1, {31'h0, irq});
      rchk("rxdata", `CSR_ADDR_RXDATA, {24'h0, b0});
      bus(1'b1, `CSR_ADDR_IRQ_CLR, 32'h3);
    end
    bus(1'b1, `CSR_ADDR_CTRL, ctrlw(1'b1, 1'b0, 1'b0, 1'b0));
    b0 = 8'($urandom);
    b1 = ~b0;
    far_u.send(b0);
    far_u.send(b1);
    repeat (6) @(posedge hclk);
    rchk("status", `CSR_ADDR_STATUS, 32'h3);
    rchk("irq_stat", `CSR_ADDR_IRQ_STAT, 32'h3);
    rchk("rxdata", `CSR_ADDR_RXDATA, {24'h0, b0});
    bus(1'b1, `CSR_ADDR_IRQ_CLR, 32'h1);
    bus(1'b1, `CSR_ADDR_IRQ_EN, 32'h0);
    far_u.send(b1);
    repeat (3) @(posedge hclk);
    chk("masked", exp_irq(2'h2, 2'h0), {31'h0, irq});
    rchk("irq_stat", `CSR_ADDR_IRQ_STAT, 32'h2);
    bus(1'b1, `CSR_ADDR_IRQ_EN, 32'h2);
    repeat (3) @(posedge hclk);
    chk("err irq", exp_irq(2'h2, 2'h2), {31'h0, irq});
    bus(1'b0, `CSR_ADDR_STATUS, 32'h0);
    bus(1'b1, `CSR_ADDR_STATUS, rd & ~32'h1);
    rchk("irq_stat", `CSR_ADDR_IRQ_STAT, 32'h0);
    bus(1'b1, `CSR_ADDR_IRQ_EN, 32'h3);
    far_u.send(b1);
    wirq();
    rchk("rxdata", `CSR_ADDR_RXDATA, {24'h0, b1});
    bus(1'b1, `CSR_ADDR_IRQ_CLR, 32'h3);
    b0 = 8'($urandom);
    far_u.arm(b0);
    bus(1'b1, `CSR_ADDR_CTRL, ctrlw(1'b1, 1'b1, 1'b1, 1'b0));
    falls = 0;
    bus(1'b1, `CSR_ADDR_TXDATA, 32'h0);
    wirq();
    repeat (20) @(posedge hclk);
    chk("falls", 32'h8, falls);
    rchk("rxdata", `CSR_ADDR_RXDATA, {24'h0, b0});
    bus(1'b1, `CSR_ADDR_IRQ_CLR, 32'h3);
    b1 = 8'($urandom);
    far_u.arm(b1);
    bus(1'b1, `CSR_ADDR_CTRL, ctrlw(1'b1, 1'b0, 1'b1, 1'b1));
    falls = 0;
    repeat (30) @(posedge hclk);
    chk("cts held", 32'h0, falls);
    cts_n <= 1'b0;
    wirq();
    rchk("rxdata", `CSR_ADDR_RXDATA, {24'h0, b1});
    bus(1'b1, `CSR_ADDR_IRQ_CLR, 32'h3);
    bus(1'b1, `CSR_ADDR_CTRL, ctrlw(1'b1, 1'b0, 1'b1, 1'b0));
    cts_n <= 1'b1;
    falls = 0;
    repeat (20) @(posedge hclk);
    chk("free run", 32'h1, {31'h0, falls > 2});
    rchk("status run", `CSR_ADDR_STATUS, 32'h4);
    bus(1'b1, `CSR_ADDR_CTRL, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
